// ---- logic/clkdiv_top.sv ----
// output divider, single-ended prescale/divider and side pin routing
// Contract
// - channel seven divider: setting N divides N+1
// - channel seven divider only on synthesizer sources
// - each side pin takes either divider
// - prescaler fed from first or second path
// - prescale codes: off, four, five, reserved
// - pin b select: div a, b, status, off
// - pin a select: div a, b, status, off
// - both pin selects reset to status
// - divider a counts prescaled clock, eight bits
// - divider a: zero disables, N divides N+1
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module clkdiv_top (
   // clock and reset; clk is the synthesizer clock
   input wire logic clk,
   input wire logic rst_b,
   // register bus
   input wire clkdiv_pkg::wb_req_t wb_req,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // sources from around the block
   input wire logic [1:0] ch7_source_sel,
   input wire logic second_path_tick,
   input wire logic ref_clk_in,
   input wire logic div_b_clk_in,
   input wire logic status_a_in,
   input wire logic status_b_in,
   // divided outputs
   output logic ch7_clk_out,
   output logic ch7_tick_out,
   output clkdiv_pkg::pin_t aux_pin_a,
   output clkdiv_pkg::pin_t aux_pin_b
);
   // next count of a wrapping counter advanced by a source tick; wrapping
   // at or above the setting lets a lowered setting take hold within one
   // period instead of rolling through all 256 counts first
   function automatic logic [7:0] nxt_count(input logic [7:0] cnt,
      input logic [7:0] last, input logic en);
      if (!en) return cnt;
      return (cnt >= last) ? 8'h00 : 8'(cnt + 8'h01);
   endfunction : nxt_count

   // high for the first ceil(ratio/2) counts of a period
   function automatic logic first_half(input logic [7:0] cnt,
      input logic [7:0] last);
      logic [8:0] half;
      half = 9'({1'b0, last} + 9'h002) >> 1;
      return {1'b0, cnt} < half;
   endfunction : first_half

   // registers
   logic [7:0] ch7_div_ff; // channel seven setting
   clkdiv_pkg::se_ctrl_t se_ctrl_ff; // prescale and pin selects
   logic [7:0] div_a_ff; // single_ended_divider_a_setting
   logic path_sel_ff; // 1 takes the second_synthesizer_path
   logic ctrl_written_ff; // control written since reset
   // bus decode
   logic req_live;
   logic [5:0] idx;
   logic wr_en;
   assign req_live = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign idx = wb_req.adr[7:2];
   assign wr_en = req_live && wb_req.we && wb_req.sel[0];

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req_live;
      end
   end

   // register writes; low byte lane only, upper lanes ignored
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ch7_div_ff <= clkdiv_pkg::CH7_DIV_RST;
         se_ctrl_ff <= clkdiv_pkg::SE_CTRL_RST;
         div_a_ff <= clkdiv_pkg::DIV_A_RST;
         path_sel_ff <= 1'b0;
         ctrl_written_ff <= 1'b0;
      end else if (wr_en) begin
         unique case (idx)
            clkdiv_pkg::IDX_CH7_DIV: ch7_div_ff <= wb_req.dat[7:0];
            clkdiv_pkg::IDX_SE_CTRL: begin
               se_ctrl_ff <= wb_req.dat[7:0];
               ctrl_written_ff <= 1'b1;
            end
            clkdiv_pkg::IDX_DIV_A: div_a_ff <= wb_req.dat[7:0];
            clkdiv_pkg::IDX_PATH:
               path_sel_ff <= wb_req.dat[clkdiv_pkg::PATH_SEL_BIT];
            default: ; // unmapped or read-only: write dropped
         endcase
      end
   end

   // the reference is an outside clock: three flops, agree on last two
   logic ref_s1_ff, ref_s2_ff, ref_s3_ff, ref_lvl_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_s1_ff <= 1'b0;
         ref_s2_ff <= 1'b0;
         ref_s3_ff <= 1'b0;
         ref_lvl_ff <= 1'b0;
      end else begin
         ref_s1_ff <= ref_clk_in;
         ref_s2_ff <= ref_s1_ff;
         ref_s3_ff <= ref_s2_ff;
         if (ref_s2_ff == ref_s3_ff) ref_lvl_ff <= ref_s3_ff;
      end
   end

   // channel seven: a reference source bypasses the divider
   logic ch7_bypass;
   logic ch7_src_tick;
   logic [7:0] ch7_cnt_ff;
   assign ch7_bypass = ch7_source_sel[1];
   assign ch7_src_tick = (ch7_source_sel == clkdiv_pkg::CH7_SYNTH) ||
      (ch7_source_sel == clkdiv_pkg::CH7_SYNTH2 && second_path_tick);

   // counter wraps at the setting: ratio is setting plus one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ch7_cnt_ff <= 8'h00;
         ch7_tick_out <= 1'b0;
         ch7_clk_out <= 1'b0;
      end else begin
         ch7_cnt_ff <= nxt_count(ch7_cnt_ff, ch7_div_ff,
            ch7_src_tick && !ch7_bypass);
         ch7_tick_out <= !ch7_bypass && ch7_src_tick &&
            ch7_cnt_ff == ch7_div_ff;
         // ratio one shows as a steady high level with a tick on each source tick
         ch7_clk_out <= ch7_bypass ? ref_lvl_ff :
            first_half(ch7_cnt_ff, ch7_div_ff);
      end
   end

   // prescaler: first path ticks every cycle, second by its strobe
   logic pre_src_tick;
   logic [2:0] pre_cnt_ff;
   logic [2:0] pre_last;
   logic pre_on;
   logic pre_tick_ff;
   assign pre_src_tick = path_sel_ff ? second_path_tick : 1'b1;
   // the reserved code is treated as off rather than guessing a ratio
   assign pre_on = se_ctrl_ff.prescale == clkdiv_pkg::PRE_DIV4 ||
      se_ctrl_ff.prescale == clkdiv_pkg::PRE_DIV5;
   assign pre_last = (se_ctrl_ff.prescale == clkdiv_pkg::PRE_DIV5) ?
      clkdiv_pkg::PRE5_LAST : clkdiv_pkg::PRE4_LAST;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt_ff <= 3'h0;
         pre_tick_ff <= 1'b0;
      end else if (!pre_on) begin
         pre_cnt_ff <= 3'h0;
         pre_tick_ff <= 1'b0;
      end else if (pre_src_tick) begin
         pre_cnt_ff <= (pre_cnt_ff >= pre_last) ? 3'h0 :
            3'(pre_cnt_ff + 3'h1);
         pre_tick_ff <= pre_cnt_ff == pre_last;
      end else begin
         pre_tick_ff <= 1'b0;
      end
   end

   // divider a: zero holds it stopped and low
   logic [7:0] div_a_cnt_ff;
   logic div_a_tick_ff;
   logic div_a_lvl_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_a_cnt_ff <= 8'h00;
         div_a_tick_ff <= 1'b0;
         div_a_lvl_ff <= 1'b0;
      end else if (div_a_ff == 8'h00) begin
         div_a_cnt_ff <= 8'h00;
         div_a_tick_ff <= 1'b0;
         div_a_lvl_ff <= 1'b0;
      end else begin
         div_a_cnt_ff <= nxt_count(div_a_cnt_ff, div_a_ff,
            pre_tick_ff);
         div_a_tick_ff <= pre_tick_ff && div_a_cnt_ff == div_a_ff;
         div_a_lvl_ff <= first_half(div_a_cnt_ff, div_a_ff);
      end
   end

   // side pin routing; a disabled pin releases its driver
   function automatic clkdiv_pkg::pin_t route(input logic [1:0] sel,
      input logic a_clk, input logic b_clk, input logic status);
      clkdiv_pkg::pin_t p;
      p = '{out: 1'b0, oe: 1'b1};
      unique case (sel)
         clkdiv_pkg::PIN_DIV_A: p.out = a_clk;
         clkdiv_pkg::PIN_DIV_B: p.out = b_clk;
         clkdiv_pkg::PIN_STATUS: p.out = status;
         clkdiv_pkg::PIN_OFF: p.oe = 1'b0;
      endcase
      return p;
   endfunction : route

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aux_pin_a <= '{out: 1'b0, oe: 1'b0};
         aux_pin_b <= '{out: 1'b0, oe: 1'b0};
      end else begin
         aux_pin_a <= route(se_ctrl_ff.pin_a, div_a_lvl_ff,
            div_b_clk_in, status_a_in);
         aux_pin_b <= route(se_ctrl_ff.pin_b, div_a_lvl_ff,
            div_b_clk_in, status_b_in);
      end
   end

   // read data; unmapped indices answer zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req_live && !wb_req.we) begin
         unique case (idx)
            clkdiv_pkg::IDX_CH7_DIV: wb_dat_o <= {24'h000000, ch7_div_ff};
            clkdiv_pkg::IDX_SE_CTRL: wb_dat_o <= {24'h000000, se_ctrl_ff};
            clkdiv_pkg::IDX_DIV_A: wb_dat_o <= {24'h000000, div_a_ff};
            clkdiv_pkg::IDX_PATH: wb_dat_o <= {31'h0, path_sel_ff};
            clkdiv_pkg::IDX_STATE: wb_dat_o <= {21'h0, pre_on, ch7_bypass,
               div_a_ff != 8'h00, div_a_cnt_ff};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // helper: cycles between channel seven ticks under a steady setup
   logic [8:0] gap_ff;
   logic gap_ok_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_ff <= 9'h001;
         gap_ok_ff <= 1'b0;
      end else begin
         gap_ff <= ch7_tick_out ? 9'h001 : 9'(gap_ff + 9'h001);
         if (wr_en || ch7_source_sel != clkdiv_pkg::CH7_SYNTH)
            gap_ok_ff <= 1'b0;
         else if (ch7_tick_out)
            gap_ok_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_ch7_ratio:
      assert property (ch7_tick_out && gap_ok_ff && $stable(ch7_div_ff) &&
         $past(ch7_source_sel) == clkdiv_pkg::CH7_SYNTH
         |-> gap_ff == 9'({1'b0, ch7_div_ff} + 9'h001))
      else $error("channel seven tick spacing wrong");
   a_ch7_bypass:
      assert property (ch7_source_sel[1] |=> ch7_clk_out ==
         $past(ref_lvl_ff) && !ch7_tick_out)
      else $error("reference source did not bypass divider");
   a_pin_a_route:
      assert property (se_ctrl_ff.pin_a == clkdiv_pkg::PIN_DIV_A |=>
         aux_pin_a.out == $past(div_a_lvl_ff) && aux_pin_a.oe)
      else $error("pin a not carrying divider a");
   a_pin_b_route:
      assert property (se_ctrl_ff.pin_b == clkdiv_pkg::PIN_DIV_B |=>
         aux_pin_b.out == $past(div_b_clk_in) && aux_pin_b.oe)
      else $error("pin b not carrying divider b");
   a_pin_off:
      assert property (se_ctrl_ff.pin_a == clkdiv_pkg::PIN_OFF |=>
         !aux_pin_a.oe)
      else $error("disabled pin still driven");
   a_status_default:
      assert property (!ctrl_written_ff |->
         se_ctrl_ff.pin_a == clkdiv_pkg::PIN_STATUS &&
         se_ctrl_ff.pin_b == clkdiv_pkg::PIN_STATUS)
      else $error("pin select lost its status default");
   a_prescale_wrap:
      assert property (pre_on && pre_src_tick && pre_cnt_ff == pre_last
         |=> pre_tick_ff && pre_cnt_ff == 3'h0)
      else $error("prescaler did not wrap at its ratio");
   a_prescale_hold:
      assert property (path_sel_ff && pre_on && !second_path_tick
         |=> $stable(pre_cnt_ff) && !pre_tick_ff)
      else $error("prescaler moved without second path tick");
   a_div_a_off:
      assert property (div_a_ff == 8'h00 |=> !div_a_tick_ff &&
         div_a_cnt_ff == 8'h00 && !div_a_lvl_ff)
      else $error("divider a ran while disabled");
   a_div_a_wrap:
      assert property (div_a_tick_ff |-> $past(div_a_cnt_ff) ==
         $past(div_a_ff) && $past(pre_tick_ff) && div_a_cnt_ff == 8'h00)
      else $error("divider a wrapped at the wrong count");
   // pin b may carry divider a just as pin a may carry divider b
   a_pin_b_div_a:
      assert property (se_ctrl_ff.pin_b == clkdiv_pkg::PIN_DIV_A |=>
         aux_pin_b.out == $past(div_a_lvl_ff) && aux_pin_b.oe)
      else $error("pin b not carrying divider a");
   a_pin_a_div_b:
      assert property (se_ctrl_ff.pin_a == clkdiv_pkg::PIN_DIV_B |=>
         aux_pin_a.out == $past(div_b_clk_in) && aux_pin_a.oe)
      else $error("pin a not carrying divider b");
   a_pin_b_off:
      assert property (se_ctrl_ff.pin_b == clkdiv_pkg::PIN_OFF |=>
         !aux_pin_b.oe)
      else $error("disabled pin b still driven");
   // the reserved prescale code must leave the prescaler parked
   a_prescale_rsvd:
      assert property (se_ctrl_ff.prescale == 2'h3 |=>
         pre_cnt_ff == 3'h0 && !pre_tick_ff)
      else $error("prescaler ran on the reserved code");
   // ack is a single-cycle pulse
   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held longer than one cycle");
endmodule : clkdiv_top

// ---- logic/clkdiv_pkg.sv ----
// constants, field layouts and carrier types of the clock divider block
package clkdiv_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [5:0] IDX_CH7_DIV = 6'h2c;
   localparam logic [5:0] IDX_SE_CTRL = 6'h2d;
   localparam logic [5:0] IDX_DIV_A = 6'h2e;
   localparam logic [5:0] IDX_PATH = 6'h2f;
   localparam logic [5:0] IDX_STATE = 6'h30;
   // reset values
   localparam logic [7:0] CH7_DIV_RST = 8'h05;
   localparam logic [7:0] SE_CTRL_RST = 8'h0a;
   localparam logic [7:0] DIV_A_RST = 8'h00;
   localparam logic [7:0] PATH_RST = 8'h00;
   // field positions
   localparam int PATH_SEL_BIT = 0;
   // prescale select codes and last count of each ratio
   localparam logic [1:0] PRE_OFF = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [1:0] PRE_DIV5 = 2'h2;
   localparam logic [2:0] PRE4_LAST = 3'h3;
   localparam logic [2:0] PRE5_LAST = 3'h4;
   // side pin source codes
   localparam logic [1:0] PIN_DIV_A = 2'h0;
   localparam logic [1:0] PIN_DIV_B = 2'h1;
   localparam logic [1:0] PIN_STATUS = 2'h2;
   localparam logic [1:0] PIN_OFF = 2'h3;
   // channel seven source codes
   localparam logic [1:0] CH7_SYNTH = 2'h0;
   localparam logic [1:0] CH7_SYNTH2 = 2'h1;
   // control register layout
   typedef struct packed {
      logic [1:0] rsvd;
      logic [1:0] prescale;
      logic [1:0] pin_b;
      logic [1:0] pin_a;
   } se_ctrl_t;
   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   // one side pin: level and its output enable
   typedef struct packed {
      logic out;
      logic oe;
   } pin_t;
endpackage : clkdiv_pkg

// ---- testbench/clk_sink_model.sv ----
// downstream receiver model: measures spacing of pulses or rising edges
`timescale 1ns/1ps
module clk_sink_model #(
   parameter bit EDGE_MODE = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // observed pulse or clock level
   input wire logic sig,
   // cycles between the last two events, and event count
   output logic [11:0] period_ff,
   output logic [15:0] hits_ff
);
   logic prev_ff; // level one edge ago
   logic [11:0] cnt_ff; // cycles since last event
   logic hit; // event seen this cycle
   // edge mode counts rises only; pulse mode counts every high cycle
   assign hit = EDGE_MODE ? (sig & ~prev_ff) : sig;
   // spacing and count of events
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_ff <= 1'b0;
         cnt_ff <= 12'h000;
         period_ff <= 12'h000;
         hits_ff <= 16'h0000;
      end else begin
         prev_ff <= sig;
         cnt_ff <= hit ? 12'h000 : cnt_ff + 12'h001;
         if (hit) begin
            period_ff <= cnt_ff + 12'h001;
            hits_ff <= hits_ff + 16'h0001;
         end
      end
   end
endmodule : clk_sink_model

// ---- testbench/tb_clkdiv_top.sv ----
// self-checking bench for the clock divider block
`timescale 1ns/1ps
module tb_clkdiv_top;
   logic clk = 1'b0; // 50 MHz
   logic rst_b = 1'b0; // held low at start
   clkdiv_pkg::wb_req_t wb_req = '0; // bus request
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   logic [1:0] ch7_source_sel = 2'h0;
   logic second_path_tick = 1'b0;
   logic ref_clk_in = 1'b0;
   logic div_b_clk_in = 1'b0;
   logic status_a_in = 1'b0;
   logic status_b_in = 1'b0;
   logic ch7_clk_out;
   logic ch7_tick_out;
   clkdiv_pkg::pin_t aux_pin_a;
   clkdiv_pkg::pin_t aux_pin_b;
   logic [11:0] tick_per; // cycles between ch7 ticks
   logic [11:0] pin_per; // cycles between pin a rises
   logic [15:0] tick_hits;
   logic [15:0] pin_hits;
   int errors = 0;
   int checks = 0;
   logic [31:0] rd; // last read data
   logic [1:0] tk = 2'h0; // second path phase, one tick in three
   logic p; // divider b level one edge ago
   logic [15:0] h;
   always #10 clk = ~clk;
   // side sources: second path tick every 3 cycles, divider b toggling
   always @(posedge clk) begin
      tk <= (tk == 2'h2) ? 2'h0 : tk + 2'h1;
      second_path_tick <= (tk == 2'h2);
      div_b_clk_in <= ~div_b_clk_in;
   end
   clkdiv_top i_clkdiv_top (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .ch7_source_sel(ch7_source_sel), .second_path_tick(second_path_tick),
      .ref_clk_in(ref_clk_in), .div_b_clk_in(div_b_clk_in),
      .status_a_in(status_a_in), .status_b_in(status_b_in),
      .ch7_clk_out(ch7_clk_out), .ch7_tick_out(ch7_tick_out),
      .aux_pin_a(aux_pin_a), .aux_pin_b(aux_pin_b));
   clk_sink_model #(.EDGE_MODE(1'b0)) i_clk_sink_model (.clk(clk),
      .rst_b(rst_b), .sig(ch7_tick_out), .period_ff(tick_per),
      .hits_ff(tick_hits));
   clk_sink_model #(.EDGE_MODE(1'b1)) i_clk_sink_model_pin (.clk(clk),
      .rst_b(rst_b), .sig(aux_pin_a.out), .period_ff(pin_per),
      .hits_ff(pin_hits));
   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle; waits for ack, only the watchdog ends a wait
   task wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
      @(posedge clk);
      // the ack of any earlier cycle must have dropped by now
      chk({31'h0, wb_ack_o}, 32'h0);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask : wb
   // reset values, unmapped read, pins in status mode
   task t_reset;
      wb(1'b0, 8'hb0, 8'h00);
      chk(rd, 32'h05);
      wb(1'b0, 8'hb4, 8'h00);
      chk(rd, 32'h0a);
      wb(1'b0, 8'hb8, 8'h00);
      chk(rd, 32'h00);
      wb(1'b0, 8'hfc, 8'h00);
      chk(rd, 32'h00);
      status_a_in <= 1'b1;
      repeat (3) @(posedge clk);
      chk({28'h0, aux_pin_a, aux_pin_b}, 32'hd);
      $display("test reset done");
   endtask : t_reset
   // channel seven ratio is setting plus one, 1 up to 256
   task t_ch7;
      logic [7:0] s[4];
      s = '{8'h00, 8'h01, 8'h04, 8'hff};
      foreach (s[i]) begin
         wb(1'b1, 8'hb0, s[i]);
         wb(1'b0, 8'hb0, 8'h00);
         chk(rd, {24'h0, s[i]});
         repeat (3 * s[i] + 6) @(posedge clk);
         chk({20'h0, tick_per}, 32'(s[i]) + 32'h1);
         // ratio one shows a steady high level
         if (s[i] == 8'h00) chk({31'h0, ch7_clk_out}, 32'h1);
      end
      $display("test ch7 done");
   endtask : t_ch7
   // reference bypasses the divider; second path keeps it
   task t_bypass;
      ch7_source_sel <= 2'h2;
      ref_clk_in <= 1'b1;
      repeat (10) @(posedge clk);
      h = tick_hits;
      chk({31'h0, ch7_clk_out}, 32'h1);
      ref_clk_in <= 1'b0;
      repeat (10) @(posedge clk);
      chk({31'h0, ch7_clk_out}, 32'h0);
      chk({16'h0, tick_hits}, {16'h0, h});
      wb(1'b1, 8'hb0, 8'h01);
      ch7_source_sel <= 2'h1;
      repeat (30) @(posedge clk);
      chk({20'h0, tick_per}, 32'h6);
      $display("test bypass done");
   endtask : t_bypass
   // write control, wait, compare pin a period
   task pin_per_is(input logic [7:0] c, input logic [31:0] e);
      wb(1'b1, 8'hb4, c);
      repeat (80) @(posedge clk);
      chk({20'h0, pin_per}, e);
   endtask : pin_per_is
   // prescale codes, divider a, path choice and pin routing
   task t_pins;
      wb(1'b1, 8'hb8, 8'h01);
      pin_per_is(8'h10, 32'h8);
      chk({31'h0, aux_pin_b.oe}, 32'h1);
      pin_per_is(8'h20, 32'ha);
      wb(1'b1, 8'hbc, 8'h01);
      pin_per_is(8'h10, 32'h18);
      pin_per_is(8'h30, 32'h18);
      // stopped prescaler: no further rises once the pipeline has drained
      h = pin_hits;
      repeat (40) @(posedge clk);
      chk({16'h0, pin_hits}, {16'h0, h});
      wb(1'b1, 8'hb4, 8'h15);
      @(posedge clk);
      p = div_b_clk_in;
      repeat (4) begin
         @(posedge clk);
         chk({30'h0, aux_pin_a.out, aux_pin_b.out}, {30'h0, p, p});
         p = div_b_clk_in;
      end
      wb(1'b1, 8'hb4, 8'h1f);
      // pins follow the select one registered cycle after the write
      @(posedge clk);
      chk({28'h0, aux_pin_a, aux_pin_b}, 32'h0);
      wb(1'b1, 8'hb4, 8'h10);
      wb(1'b1, 8'hb8, 8'h00);
      repeat (40) @(posedge clk);
      chk({31'h0, aux_pin_a.out}, 32'h0);
      // state word: prescaler on, no bypass, divider a off, count zero
      wb(1'b0, 8'hc0, 8'h00);
      chk(rd, 32'h400);
      $display("test pins done");
   endtask : t_pins
   // counts, verdict, end of run
   task give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_ch7();
      t_bypass();
      t_pins();
      give_verdict();
   end
   // watchdog: whole run needs about 1400 cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule : tb_clkdiv_top
